// ### core/async_serial_receiver_core.sv
// Contract
// RQ1: parity checked only when parity enable set
// RQ2: odd select bit picks odd or even
// RQ3: select zero is even, one is odd
// RQ4: parity result stored with data and stop
// RQ5: parity flag shown for head character only
// RQ6: disable stops reception, drops current frame
// RQ7: disabled receiver releases the pin override
// RQ8: disable empties buffer and its status
// RQ9: software flushes by reading until empty
// RQ10: sample at 16x, or 8x double speed
// RQ11: falling edge starts detection, sample one
// RQ12: start needs majority low at centre
// RQ13: resynchronise timing on every valid start
// RQ14: sixteen or eight states per bit
// RQ15: each bit is majority of three
// RQ16: same centre samples for every bit
// RQ17: frame ends at first stop bit
// RQ18: low stop bit sets frame error
// RQ19: next start right after stop voting; in double speed the code waits one more sample before edge search
// RQ20: complete flag high while buffer holds data
// RQ21: two-deep buffer, overrun on third start; code flags it on the fourth start, with a frame parked
// RQ22: flags travel with frame, read advances
`include "rx_core_cfg.svh"
`default_nettype none
module async_serial_receiver_core
  import rx_core_pkg::*;
#(
  parameter int DATA_BITS = 8,
  parameter int BUF_DEPTH = `RXC_BUF_DEPTH
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire bus_req_s bus_req,
  output logic [7:0] rdata,
  input wire logic sample_tick,
  input wire logic serial_receive_pin,
  output logic rx_pin_override
);

  // buffer pointer and occupancy widths
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(BUF_DEPTH);
  // bit counter end and realignment of short characters
  localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);
  localparam logic [3:0] ALIGN = 4'(8 - DATA_BITS);

  // refuse shapes the datapath cannot serve
  if (DATA_BITS < 5 || DATA_BITS > 8)
  begin : g_bad_bits
    $error("DATA_BITS must be 5 to 8");
  end
  if (BUF_DEPTH < 2 || BUF_DEPTH != (2 ** PW))
  begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two, at least 2");
  end

  typedef struct packed
  {
    rx_state_e state;
    ctrl_s ctrl;
    logic line_prev;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic par_err;
    logic dbl_hold;
    logic wait_v;
    entry_s wait_e;
    logic ovr_pend;
    logic [PW-1:0] rptr;
    logic [PW-1:0] wptr;
    logic [CW-1:0] count;
    logic [7:0] rdata;
    logic pin_ovr;
  } core_s;

  core_s q;
  core_s d;

  entry_s head;
  entry_s done_e;
  entry_s mem_wdata;
  logic mem_we;
  logic [PW-1:0] mem_waddr;
  logic vote;
  logic voted;
  logic start_det;
  logic frame_done;
  logic pop;
  logic room;
  logic ovr_evt;
  logic [7:0] stat;

  // the buffer holds at least one unread character
  function automatic logic has_data(input logic [CW-1:0] c);
    has_data = (c != '0);
  endfunction

  // every slot taken: unless a read pops in the same cycle, a finished frame waits in the hold register
  function automatic logic is_full(input logic [CW-1:0] c);
    is_full = (c == FULL);
  endfunction

  // one when data plus parity bit disagree with the chosen sense
  function automatic logic parity_bad(input logic [7:0] data, input logic pbit,
    input logic odd);
    parity_bad = ^data ^ pbit ^ odd; // RQ2 RQ3
  endfunction

  // a finished frame as it enters the buffer; overrun is added on the write
  function automatic entry_s make_entry(input logic [7:0] sh, input logic perr,
    input logic stop);
    make_entry = '0;
    make_entry.data = sh >> ALIGN;
    make_entry.parity_error_flag = perr; // RQ4
    make_entry.frame_error_flag = ~stop; // RQ18
  endfunction

  // status byte: head flags are masked so an empty buffer reads them as zero; busy is not masked
  function automatic logic [7:0] pack_status(input logic avail, input entry_s e,
    input logic busy);
    pack_status = 8'h00;
    pack_status[`RXC_STAT_RXC] = avail; // RQ20
    pack_status[`RXC_STAT_FE] = avail & e.frame_error_flag;
    pack_status[`RXC_STAT_DOR] = avail & e.overrun_flag;
    pack_status[`RXC_STAT_PE] = avail & e.parity_error_flag; // RQ5
    pack_status[`RXC_STAT_BUSY] = busy;
  endfunction

  // falling edge on an idle, enabled line; the tick is sample one
  assign start_det = sample_tick && q.ctrl.receiver_enable && (q.state == ST_IDLE)
    && q.line_prev && !serial_receive_pin; // RQ11

  rx_bit_sampler u_sampler (
    .mclk(mclk),
    .resetn(resetn),
    .sample_tick(sample_tick),
    .restart(start_det),
    .line(serial_receive_pin),
    .dbl(q.ctrl.double_speed_select),
    .vote(vote),
    .voted(voted)
  );

  // head word always tracks the next read pointer, so no stale cycle
  rx_buffer_mem #(
    .WIDTH($bits(entry_s)),
    .AW(PW)
  ) u_buf (
    .mclk(mclk),
    .resetn(resetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(d.rptr),
    .rdata(head)
  );

  // the whole next state of the receiver
  always_comb
  begin
    d = q;
    frame_done = 1'b0;
    mem_we = 1'b0;
    mem_waddr = q.wptr;
    mem_wdata = q.wait_e;
    ovr_evt = 1'b0;
    stat = 8'h00;
    done_e = make_entry(q.shreg, q.par_err, vote); // RQ4 RQ18

    // line history for edge search, taken once per sample
    if (sample_tick)
      d.line_prev = serial_receive_pin;

    // frame sequencer, advanced on each voted bit
    case (q.state)
      // idle: the edge search itself lives in start_det
      ST_IDLE:
      begin
        d.dbl_hold = 1'b0;
        if (start_det)
          d.state = ST_START;
      end
      // start bit: a low centre vote confirms it, a high one is noise
      ST_START:
      begin
        if (voted)
        begin
          if (vote)
            d.state = ST_IDLE; // RQ12
          else
          begin
            d.state = ST_DATA; // RQ13
            d.bitcnt = 4'h0;
            d.shreg = 8'h00;
            d.par_err = 1'b0;
          end
        end
      end
      // data bits: one voted bit per bit period
      ST_DATA:
      begin
        if (voted)
        begin
          // lsb first; short characters are realigned when stored
          d.shreg = {vote, q.shreg[7:1]};
          d.bitcnt = q.bitcnt + 4'h1;
          if (q.bitcnt == LAST_BIT)
          begin
            if (q.ctrl.parity_enable_bit)
              d.state = ST_PARITY; // RQ1
            else
              d.state = ST_STOP;
          end
        end
      end
      // parity bit: judged only while checking is enabled
      ST_PARITY:
      begin
        if (voted)
        begin
          // even: data plus parity bit must hold an even count of ones
          d.par_err = q.ctrl.parity_enable_bit
            & parity_bad(q.shreg, vote, q.ctrl.parity_odd_select); // RQ1 RQ2 RQ3
          d.state = ST_STOP;
        end
      end
      // first stop bit closes the frame; later stop bits are plain idle
      ST_STOP:
      begin
        if (q.dbl_hold)
        begin
          // double speed waits one more sample before edge search
          if (sample_tick)
          begin
            d.state = ST_IDLE; // RQ19
            d.dbl_hold = 1'b0;
          end
        end
        else if (voted)
        begin
          frame_done = 1'b1; // RQ17
          if (q.ctrl.double_speed_select)
            d.dbl_hold = 1'b1;
          else
            d.state = ST_IDLE; // RQ19
        end
      end
      default:
        d.state = ST_IDLE;
    endcase

    // a read of the data word retires the head character
    pop = bus_req.rd && (bus_req.addr == `RXC_ADDR_DATA) && has_data(q.count); // RQ22
    room = !is_full(q.count) || pop;

    // a third character waits in the hold register; a start then overruns
    if (start_det && is_full(q.count) && q.wait_v)
      ovr_evt = 1'b1; // RQ21

    // the hold register drains first so characters keep arrival order
    if (q.wait_v && room)
    begin
      mem_we = 1'b1;
      mem_wdata = q.wait_e;
      d.wait_v = 1'b0;
    end
    else if (frame_done && room)
    begin
      mem_we = 1'b1;
      mem_wdata = done_e;
    end
    mem_wdata.overrun_flag = q.ovr_pend; // RQ22

    // frame finished but no room yet: park it, newest one wins
    if (frame_done && !(mem_we && !q.wait_v))
    begin
      d.wait_v = 1'b1;
      d.wait_e = done_e;
    end

    // a new overrun beats the clear from a push in the same cycle
    d.ovr_pend = (q.ovr_pend & ~mem_we) | ovr_evt;
    d.wptr = q.wptr + PW'(mem_we);
    d.rptr = q.rptr + PW'(pop);
    d.count = q.count + CW'(mem_we) - CW'(pop); // RQ21

    // status shows the head character, or zero flags with only busy when empty
    stat = pack_status(has_data(q.count), head, q.state != ST_IDLE); // RQ5 RQ20

    // read data stand for exactly one cycle after the strobe
    d.rdata = 8'h00;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `RXC_ADDR_CTRL:
          d.rdata = {4'h0, q.ctrl};
        `RXC_ADDR_STAT:
          d.rdata = stat;
        `RXC_ADDR_DATA:
          d.rdata = has_data(q.count) ? head.data : 8'h00;
        default:
          d.rdata = 8'h00;
      endcase
    end

    // only the control word is writable; status and data ignore writes
    if (bus_req.wr && (bus_req.addr == `RXC_ADDR_CTRL))
      d.ctrl = bus_req.wdata[3:0];

    // disable is immediate: drop the frame in flight and the buffer
    if (!q.ctrl.receiver_enable)
    begin
      d.state = ST_IDLE; // RQ6
      d.dbl_hold = 1'b0;
      d.wait_v = 1'b0; // RQ8
      d.ovr_pend = 1'b0;
      d.count = '0;
      d.rptr = '0;
      d.wptr = '0;
      mem_we = 1'b0;
    end

    // override lags the enable by one cycle so the pin comes from a flop
    d.pin_ovr = q.ctrl.receiver_enable; // RQ7
  end

  // one register stage for all state
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.state <= ST_IDLE;
      q.ctrl <= `RXC_CTRL_RST;
      // starts high so an idle line never looks like a falling edge
      q.line_prev <= 1'b1;
    end
    else
      q <= d;
  end

  assign rdata = q.rdata;
  assign rx_pin_override = q.pin_ovr;

endmodule
`default_nettype wire

// ### core/rx_bit_sampler.sv
`include "rx_core_cfg.svh"
`default_nettype none
module rx_bit_sampler
  import rx_core_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sample_tick,
  input wire logic restart,
  input wire logic line,
  input wire logic dbl,
  output logic vote,
  output logic voted
);

  typedef struct packed
  {
    logic [4:0] cnt;
    logic [2:0] win;
    logic voted;
  } smp_s;

  smp_s q;
  smp_s d;
  logic [4:0] spb;
  logic [4:0] first;
  logic [4:0] last;

  // sample counter; restart marks the first low sample as sample one
  always_comb
  begin
    spb = dbl ? `RXC_SPB_DBL : `RXC_SPB_NORM; // RQ10 RQ14
    first = dbl ? `RXC_VOTE_FIRST_DBL : `RXC_VOTE_FIRST_NORM; // RQ16
    last = dbl ? `RXC_VOTE_LAST_DBL : `RXC_VOTE_LAST_NORM;
    d = q;
    d.voted = 1'b0;
    if (sample_tick)
    begin
      if (restart)
      begin
        d.cnt = 5'h01; // RQ11 RQ13
        d.win = 3'h0;
      end
      else
      begin
        // wrap on >= so a mode change mid-bit cannot run away
        d.cnt = (q.cnt >= spb) ? 5'h01 : q.cnt + 5'h01;
        if (d.cnt >= first && d.cnt <= last)
        begin
          d.win = {q.win[1:0], line};
          d.voted = (d.cnt == last);
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign vote = majority3(q.win); // RQ15
  assign voted = q.voted;

endmodule
`default_nettype wire

// ### core/rx_buffer_mem.sv
`default_nettype none
module rx_buffer_mem #(
  parameter int WIDTH = 11,
  parameter int AW = 1
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  localparam int DEPTH = 2 ** AW;

  // a single word has no address bit to serve
  if (AW < 1)
  begin : g_bad_aw
    $error("AW must be at least 1");
  end

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] word;
    logic [WIDTH-1:0] rd;
  } mem_s;

  mem_s q;
  mem_s d;

  // read sees a write to the same word in the same cycle
  always_comb
  begin
    d = q;
    if (we)
      d.word[waddr] = wdata;
    d.rd = d.word[raddr];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign rdata = q.rd;

endmodule
`default_nettype wire

// ### core/rx_core_cfg.svh
`ifndef RX_CORE_CFG_SVH
`define RX_CORE_CFG_SVH
// register word addresses
`define RXC_ADDR_CTRL 2'h0
`define RXC_ADDR_STAT 2'h1
`define RXC_ADDR_DATA 2'h2
// control field positions and reset value
`define RXC_CTRL_EN 0
`define RXC_CTRL_DBL 1
`define RXC_CTRL_PEN 2
`define RXC_CTRL_ODD 3
`define RXC_CTRL_RST 4'h0
// status field positions
`define RXC_STAT_RXC 0
`define RXC_STAT_FE 1
`define RXC_STAT_DOR 2
`define RXC_STAT_PE 3
`define RXC_STAT_BUSY 4
// oversampling: samples per bit and centre window
`define RXC_SPB_NORM 5'h10
`define RXC_SPB_DBL 5'h08
`define RXC_VOTE_FIRST_NORM 5'h08
`define RXC_VOTE_LAST_NORM 5'h0A
`define RXC_VOTE_FIRST_DBL 5'h04
`define RXC_VOTE_LAST_DBL 5'h06
`define RXC_BUF_DEPTH 2
`endif

// ### core/rx_core_pkg.sv
`default_nettype none
package rx_core_pkg;

  // receive frame sequencer states
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP = 5'h10
  } rx_state_e;

  typedef struct packed
  {
    logic parity_odd_select;
    logic parity_enable_bit;
    logic double_speed_select;
    logic receiver_enable;
  } ctrl_s;

  // one buffered character with its own status
  typedef struct packed
  {
    logic overrun_flag;
    logic parity_error_flag;
    logic frame_error_flag;
    logic [7:0] data;
  } entry_s;

  typedef struct packed
  {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

endpackage
`default_nettype wire

// ### dv/async_serial_receiver_core_checker.sv
`include "rx_core_cfg.svh"
`default_nettype none
module async_serial_receiver_core_checker
  import rx_core_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire bus_req_s bus_req,
  input wire logic [7:0] rdata,
  input wire logic sample_tick,
  input wire logic serial_receive_pin,
  input wire logic rx_pin_override
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  logic cw;
  logic [3:0] ctrl_q;
  // control write strobe, shared by the enable checks
  assign cw = bus_req.wr && bus_req.addr == `RXC_ADDR_CTRL;
  // shadow of the control word so read-back is judged independently
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ctrl_q <= 4'h0;
    else if (cw)
      ctrl_q <= bus_req.wdata[3:0];
  end
  sequence rd_at(logic [1:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  sequence ctrl_wr;
    cw;
  endsequence
  rdata_idle_a: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("rdata not zero without a read");
  unmapped_read_a: assert property (rd_at(2'h3) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (rd_at(`RXC_ADDR_CTRL) |=> rdata[3:0] == $past(ctrl_q))
    else $error("control read-back wrong");
  enable_follow_a: assert property (
    ctrl_wr |-> ##2 rx_pin_override == $past(bus_req.wdata[0], 2))
    else $error("override does not follow enable");
  override_cause_a: assert property ($changed(rx_pin_override) |-> $past(cw, 2))
    else $error("override changed without control write");
  off_status_a: assert property (
    !rx_pin_override ##0 rd_at(`RXC_ADDR_STAT) |=> rdata == 8'h00)
    else $error("status not clear while disabled");
  off_data_a: assert property (
    !rx_pin_override ##0 rd_at(`RXC_ADDR_DATA) |=> rdata == 8'h00)
    else $error("data left while disabled");
  stat_spare_a: assert property (rd_at(`RXC_ADDR_STAT) |=> rdata[7:5] == 3'h0)
    else $error("status spare bits set");
  enable_seen_c: cover property (ctrl_wr ##2 rx_pin_override);
endmodule
bind async_serial_receiver_core async_serial_receiver_core_checker i_chk (.mclk(mclk),
  .resetn(resetn), .bus_req(bus_req), .rdata(rdata), .sample_tick(sample_tick),
  .serial_receive_pin(serial_receive_pin), .rx_pin_override(rx_pin_override));
`default_nettype wire

// ### dv/async_serial_receiver_core_tb_top.sv
`include "rx_core_cfg.svh"
`default_nettype none
`define CHK(n, e, s) \
  begin cmp_count++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module async_serial_receiver_core_tb_top
  import rx_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic sample_tick = 1'b0;
  logic [1:0] tcnt = 2'h0;
  bus_req_s bus_req = '0;
  logic [7:0] rdata;
  logic rx_pin_override;
  logic line;
  int errors = 0;
  int cmp_count = 0;
  async_serial_receiver_core i_async_serial_receiver_core (.mclk(mclk), .resetn(resetn),
    .bus_req(bus_req), .rdata(rdata), .sample_tick(sample_tick),
    .serial_receive_pin(line), .rx_pin_override(rx_pin_override));
  serial_tx_model i_serial_tx_model (.mclk(mclk), .sample_tick(sample_tick), .line(line));
  // 20 MHz clock
  always #25 mclk = ~mclk;
  // oversample tick every third cycle keeps ticks apart as required
  always @(posedge mclk)
  begin
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    sample_tick <= (tcnt == 2'h2);
  end
  task automatic finish_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bw(input logic [1:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '0;
    @(posedge mclk);
  endtask
  task automatic br(input logic [1:0] a, output logic [7:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask
  // even parity bit is the xor of the data; odd inverts it
  function automatic logic [10:0] mkf(input logic [7:0] d, input logic pen, input logic odd,
    input logic bad, input logic stp);
    logic p;
    p = ^d ^ odd ^ bad;
    mkf = pen ? {stp, p, d, 1'b0} : {1'b0, stp, d, 1'b0};
  endfunction
  // status first, then data pops the head
  task automatic expect_char(input logic [7:0] d, input logic fe, input logic pe,
    input logic dor);
    logic [7:0] v;
    br(`RXC_ADDR_STAT, v);
    `CHK("status", {3'h0, 1'b0, pe, dor, fe, 1'b1}, v);
    br(`RXC_ADDR_DATA, v);
    `CHK("data", d, v);
  endtask
  // watchdog sized well above the roughly 10000 cycles of the run
  initial
  begin
    repeat (60000) @(posedge mclk);
    errors++;
    finish_test();
  end
  initial
  begin
    logic [7:0] v;
    logic [7:0] d [4];
    logic st [2];
    logic bad [2];
    int spb;
    void'($urandom(92));
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    // every mode: noise start, back-to-back pair with shortest legal stop
    for (int m = 0; m < 8; m++)
    begin
      spb = m[0] ? 8 : 16;
      bw(`RXC_ADDR_CTRL, {4'h0, m[2:0], 1'b1});
      i_serial_tx_model.glitch(spb);
      for (int k = 0; k < 2; k++)
      begin
        d[k] = (m == 0) ? 8'hFF : 8'($urandom);
        st[k] = ($urandom % 3) != 0;
        bad[k] = 1'($urandom);
        i_serial_tx_model.send(mkf(d[k], m[1], m[2], bad[k], st[k]), m[1] ? 10 : 9,
          spb, (k == 0) ? (m[0] ? 6 : 9) : spb);
      end
      repeat (4) @(posedge mclk);
      for (int k = 0; k < 2; k++)
        expect_char(d[k], !st[k], m[1] & bad[k], 1'b0);
    end
    // four frames unread: third parked then overwritten, flagged lost
    bw(`RXC_ADDR_CTRL, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      d[k] = 8'($urandom);
      i_serial_tx_model.send(mkf(d[k], 1'b0, 1'b0, 1'b0, 1'b1), 9, 16, 16);
    end
    repeat (4) @(posedge mclk);
    expect_char(d[0], 1'b0, 1'b0, 1'b0);
    expect_char(d[1], 1'b0, 1'b0, 1'b0);
    expect_char(d[3], 1'b0, 1'b0, 1'b1);
    br(`RXC_ADDR_STAT, v);
    `CHK("status empty", 8'h00, v);
    br(2'h3, v);
    `CHK("unmapped", 8'h00, v);
    bw(`RXC_ADDR_STAT, 8'hFF);
    br(`RXC_ADDR_CTRL, v);
    `CHK("control", 4'h1, v[3:0]);
    // one buffered, then disable in mid-frame
    i_serial_tx_model.send(mkf(8'hA5, 1'b0, 1'b0, 1'b0, 1'b1), 9, 16, 16);
    fork
      i_serial_tx_model.send(mkf(8'h3C, 1'b0, 1'b0, 1'b0, 1'b1), 9, 16, 16);
      begin
        repeat (190) @(posedge mclk);
        br(`RXC_ADDR_STAT, v);
        `CHK("status busy", 8'h11, v);
        bw(`RXC_ADDR_CTRL, 8'h00);
      end
    join
    `CHK("override", 1'b0, rx_pin_override);
    br(`RXC_ADDR_STAT, v);
    `CHK("status off", 8'h00, v);
    br(`RXC_ADDR_DATA, v);
    `CHK("data off", 8'h00, v);
    bw(`RXC_ADDR_CTRL, 8'h01);
    @(posedge mclk);
    `CHK("override", 1'b1, rx_pin_override);
    br(`RXC_ADDR_STAT, v);
    `CHK("status on", 8'h00, v);
    // a fresh frame after re-enable must be the only character seen
    i_serial_tx_model.send(mkf(8'h5A, 1'b0, 1'b0, 1'b0, 1'b1), 9, 16, 16);
    repeat (4) @(posedge mclk);
    expect_char(8'h5A, 1'b0, 1'b0, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire

// ### dv/serial_tx_model.sv
`default_nettype none
module serial_tx_model
(
  input wire logic mclk,
  input wire logic sample_tick,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle line rests high between frames
  initial line = 1'b1;
  // level changes just after a tick edge, so each tick sees one value
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge mclk iff sample_tick);
  endtask
  // start, lsb-first bits, then one stop of sl ticks plus one idle tick
  task automatic send(input logic [10:0] b, input int n, input int spb, input int sl);
    int i;
    @(posedge mclk iff sample_tick);
    for (i = 0; i < n; i++)
      hold(b[i], spb);
    hold(b[n], sl);
    line <= 1'b1;
  endtask
  // three low ticks: too short to pass the centre vote
  task automatic glitch(input int spb);
    @(posedge mclk iff sample_tick);
    hold(1'b0, 3);
    hold(1'b1, 2 * spb);
  endtask
endmodule
`default_nettype wire
